/* File: rtl/ipk_pkg.sv */
// Package with constants and carrier types for the drive operating panel key and indicator logic.
// Operation
// R1: When stopped, forward lamp steady while a forward command is valid.
// R2: When running forward, forward lamp steady.
// R3: Forward lamp flashes while changing from forward to reverse rotation.
// R4: Reverse lamp steady on valid reverse command when stopped, or running reverse.
// R5: Reverse lamp flashes while changing from reverse to forward rotation.
// R6: Unit lamps: Hz, A, V; Hz+A marks speed unit, A+V marks percent.
// R7: Drive five seven-segment digit positions showing values or fault codes.
// R8: Programming key enters the first menu level, or exits when inside.
// R9: Confirm key descends one menu level; at value level it accepts the edit.
// R10: Increment key raises value or advances function code by one step.
// R11: Decrement key lowers value or steps function code back by one step.
// R12: On stop and run screens, shift key cycles the monitored quantity.
// R13: While editing a value, shift key moves the editable digit position.
// R14: In keypad command mode, run key issues a run command.
// R15: While running, stop key issues a stop command; code does so only in keypad mode or with setting bit 0, not during a fault.
// R16: With a fault active, stop key resets fault, as stop key setting permits.
// R17: Multifunction key performs the function chosen by its assignment setting.
// R18: Every key is debounced and acts once per press; one fixed blink period.
package ipk_pkg;

   // ------------------------------------------------------------
   // Key indices
   // ------------------------------------------------------------
   localparam int KEY_COUNT = 8;
   localparam int KEY_PROG = 0;
   localparam int KEY_CONFIRM = 1;
   localparam int KEY_INC = 2;
   localparam int KEY_DEC = 3;
   localparam int KEY_SHIFT = 4;
   localparam int KEY_RUN = 5;
   localparam int KEY_STOP = 6;
   localparam int KEY_MULTI = 7;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int DEBOUNCE_MS = 10;
   localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * 1000 * CLK_MHZ;
   localparam int BLINK_HALF_MS = 250;
   localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * 1000 * CLK_MHZ;

   // ------------------------------------------------------------
   // Display
   // ------------------------------------------------------------
   localparam int DIGIT_COUNT = 5;
   localparam int SEG_W = 8;
   localparam int MON_W = 3;
   localparam logic [2:0] MON_LAST = 3'h7;
   localparam logic [2:0] DIGIT_LAST = 3'h4;
   localparam logic [2:0] ZERO3 = 3'h0;
   localparam logic [2:0] ONE3 = 3'h1;

   // ------------------------------------------------------------
   // Settings encodings
   // ------------------------------------------------------------
   // Stop key behaviour: bit 0 enables stop in non-keypad command modes, bit 1 enables fault reset.
   localparam int STOP_SET_STOP_ANY = 0;
   localparam int STOP_SET_RESET = 1;

   typedef enum logic [2:0] {
      IPK_MK_NONE = 3'b000,
      IPK_MK_CMD_SWITCH = 3'b001,
      IPK_MK_DIR_SWITCH = 3'b010,
      IPK_MK_JOG_FWD = 3'b011,
      IPK_MK_JOG_REV = 3'b100,
      IPK_MK_VIEW_MODE = 3'b101
   } ipk_mk_func_t;

   typedef enum logic [1:0] {
      IPK_UNIT_HZ = 2'b00,
      IPK_UNIT_A = 2'b01,
      IPK_UNIT_V = 2'b10,
      IPK_UNIT_SPEED = 2'b11
   } ipk_unit_t;

   typedef enum logic [1:0] {
      IPK_MENU_SCREEN = 2'b00,
      IPK_MENU_GROUP = 2'b01,
      IPK_MENU_CODE = 2'b10,
      IPK_MENU_VALUE = 2'b11
   } ipk_menu_t;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic running;
      logic dir_rev;
      logic fwd_cmd_valid;
      logic rev_cmd_valid;
      logic changing_over;
      logic fault_active;
      logic keypad_mode;
      logic percent_unit;
      ipk_unit_t unit;
   } ipk_drive_state_t;

   typedef struct packed {
      logic lamp_fwd;
      logic lamp_rev;
      logic lamp_hz;
      logic lamp_a;
      logic lamp_v;
   } ipk_lamps_t;

   typedef struct packed {
      logic run_cmd;
      logic stop_cmd;
      logic fault_reset;
      logic value_inc;
      logic value_dec;
      logic code_inc;
      logic code_dec;
      logic accept_edit;
      logic cancel_edit;
      logic mk_cmd_switch;
      logic mk_dir_switch;
      logic mk_jog_fwd;
      logic mk_jog_rev;
      logic mk_view_mode;
   } ipk_actions_t;

endpackage : ipk_pkg

/* File: rtl/ipk_panel.sv */
// Operating panel logic: key debounce, menu actions, direction and unit lamps, digit drive.
`timescale 1ns/1ps

module ipk_panel #(
   parameter int DEBOUNCE_CYCLES = ipk_pkg::DEBOUNCE_CYCLES,
   parameter int BLINK_HALF_CYCLES = ipk_pkg::BLINK_HALF_CYCLES
) (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_clk_en,
   input wire logic [ipk_pkg::KEY_COUNT-1:0] i_key_pins_n,
   input wire ipk_pkg::ipk_drive_state_t i_drive,
   input wire logic [1:0] i_stop_key_behaviour_setting,
   input wire ipk_pkg::ipk_mk_func_t i_multifunction_key_assignment,
   input wire logic [ipk_pkg::DIGIT_COUNT*ipk_pkg::SEG_W-1:0] i_digit_segs,
   output ipk_pkg::ipk_lamps_t o_lamps,
   output logic [ipk_pkg::DIGIT_COUNT*ipk_pkg::SEG_W-1:0] o_digit_segs,
   output logic [ipk_pkg::DIGIT_COUNT-1:0] o_digit_flash,
   output ipk_pkg::ipk_menu_t o_menu_level,
   output logic [ipk_pkg::MON_W-1:0] o_monitor_sel,
   output logic [2:0] o_edit_digit,
   output ipk_pkg::ipk_actions_t o_actions
);

   localparam int KN = ipk_pkg::KEY_COUNT;
   localparam int DN = ipk_pkg::DIGIT_COUNT;
   localparam int DBW = $clog2(DEBOUNCE_CYCLES + 1);
   localparam int BKW = $clog2(BLINK_HALF_CYCLES + 1);
   localparam logic [DBW-1:0] DB_LAST = DBW'(DEBOUNCE_CYCLES - 1);
   localparam logic [BKW-1:0] BK_LAST = BKW'(BLINK_HALF_CYCLES - 1);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [KN-1:0] sync1;
      logic [KN-1:0] sync2;
      logic [KN-1:0] stable;
      logic [KN-1:0][DBW-1:0] db_cnt;
      logic [BKW-1:0] blink_cnt;
      logic blink;
      ipk_pkg::ipk_menu_t menu;
      logic [ipk_pkg::MON_W-1:0] mon_sel;
      logic [2:0] edit_digit;
      ipk_pkg::ipk_lamps_t lamps;
      logic [DN*ipk_pkg::SEG_W-1:0] segs;
      logic [DN-1:0] flash;
      ipk_pkg::ipk_actions_t act;
   } ipk_state_t;

   ipk_state_t state_reg;
   ipk_state_t state_next;
   logic [KN-1:0] press;
   logic [KN-1:0] db_done;
   logic [KN-1:0] key_lvl;

   // ------------------------------------------------------------
   // Debounce per key
   // ------------------------------------------------------------
   // A key level must hold for the full debounce time before the stable copy follows it.
   genvar g;
   generate
      for (g = 0; g < KN; g = g + 1) begin : g_key
         assign key_lvl[g] = ~state_reg.sync2[g];
         assign db_done[g] = (key_lvl[g] != state_reg.stable[g]) && (state_reg.db_cnt[g] == DB_LAST); // R18
         assign press[g] = db_done[g] && key_lvl[g]; // R18
      end
   endgenerate

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      state_next.sync1 = i_key_pins_n;
      state_next.sync2 = state_reg.sync1;
      state_next.act = '0;
      for (int k = 0; k < KN; k++) begin
         if (key_lvl[k] == state_reg.stable[k]) begin
            state_next.db_cnt[k] = '0;
         end else if (db_done[k]) begin
            state_next.db_cnt[k] = '0;
            state_next.stable[k] = key_lvl[k];
         end else begin
            state_next.db_cnt[k] = state_reg.db_cnt[k] + DBW'(1);
         end
      end

      // One fixed blink period for every flashing lamp.
      if (state_reg.blink_cnt == BK_LAST) begin // R18
         state_next.blink_cnt = '0;
         state_next.blink = ~state_reg.blink;
      end else begin
         state_next.blink_cnt = state_reg.blink_cnt + BKW'(1);
      end

      // Direction lamps.
      state_next.lamps.lamp_fwd = 1'b0;
      state_next.lamps.lamp_rev = 1'b0;
      if (i_drive.changing_over) begin
         state_next.lamps.lamp_fwd = ~i_drive.dir_rev & state_reg.blink; // R3
         state_next.lamps.lamp_rev = i_drive.dir_rev & state_reg.blink; // R5
      end else if (i_drive.running) begin
         state_next.lamps.lamp_fwd = ~i_drive.dir_rev; // R2
         state_next.lamps.lamp_rev = i_drive.dir_rev; // R4
      end else begin
         state_next.lamps.lamp_fwd = i_drive.fwd_cmd_valid; // R1
         state_next.lamps.lamp_rev = i_drive.rev_cmd_valid; // R4
      end

      // Unit lamps.
      state_next.lamps.lamp_hz = 1'b0;
      state_next.lamps.lamp_a = 1'b0;
      state_next.lamps.lamp_v = 1'b0;
      if (i_drive.percent_unit) begin
         state_next.lamps.lamp_a = 1'b1; // R6
         state_next.lamps.lamp_v = 1'b1; // R6
      end else begin
         case (i_drive.unit)
            ipk_pkg::IPK_UNIT_HZ: begin
               state_next.lamps.lamp_hz = 1'b1; // R6
            end
            ipk_pkg::IPK_UNIT_A: begin
               state_next.lamps.lamp_a = 1'b1; // R6
            end
            ipk_pkg::IPK_UNIT_V: begin
               state_next.lamps.lamp_v = 1'b1; // R6
            end
            ipk_pkg::IPK_UNIT_SPEED: begin
               state_next.lamps.lamp_hz = 1'b1; // R6
               state_next.lamps.lamp_a = 1'b1; // R6
            end
            default: begin
               state_next.lamps.lamp_hz = 1'b0;
            end
         endcase
      end

      // Digits are registered; the editable digit flashes while editing.
      state_next.segs = i_digit_segs; // R7
      state_next.flash = '0;
      if (state_reg.menu == ipk_pkg::IPK_MENU_VALUE) begin
         state_next.flash[state_reg.edit_digit] = 1'b1; // R13
      end

      // Menu keys.
      if (press[ipk_pkg::KEY_PROG]) begin
         if (state_reg.menu == ipk_pkg::IPK_MENU_SCREEN) begin
            state_next.menu = ipk_pkg::IPK_MENU_GROUP; // R8
         end else begin
            if (state_reg.menu == ipk_pkg::IPK_MENU_VALUE) begin
               state_next.act.cancel_edit = 1'b1;
            end
            state_next.menu = ipk_pkg::IPK_MENU_SCREEN; // R8
         end
      end else if (press[ipk_pkg::KEY_CONFIRM]) begin
         case (state_reg.menu)
            ipk_pkg::IPK_MENU_SCREEN: begin
               state_next.menu = ipk_pkg::IPK_MENU_GROUP; // R9
            end
            ipk_pkg::IPK_MENU_GROUP: begin
               state_next.menu = ipk_pkg::IPK_MENU_CODE; // R9
            end
            ipk_pkg::IPK_MENU_CODE: begin
               state_next.menu = ipk_pkg::IPK_MENU_VALUE; // R9
               state_next.edit_digit = ipk_pkg::ZERO3;
            end
            ipk_pkg::IPK_MENU_VALUE: begin
               state_next.act.accept_edit = 1'b1; // R9
               state_next.menu = ipk_pkg::IPK_MENU_CODE;
            end
            default: begin
               state_next.menu = ipk_pkg::IPK_MENU_SCREEN;
            end
         endcase
      end else if (press[ipk_pkg::KEY_INC]) begin
         if (state_reg.menu == ipk_pkg::IPK_MENU_VALUE) begin
            state_next.act.value_inc = 1'b1; // R10
         end else begin
            state_next.act.code_inc = 1'b1; // R10
         end
      end else if (press[ipk_pkg::KEY_DEC]) begin
         if (state_reg.menu == ipk_pkg::IPK_MENU_VALUE) begin
            state_next.act.value_dec = 1'b1; // R11
         end else begin
            state_next.act.code_dec = 1'b1; // R11
         end
      end else if (press[ipk_pkg::KEY_SHIFT]) begin
         if (state_reg.menu == ipk_pkg::IPK_MENU_VALUE) begin
            state_next.edit_digit = (state_reg.edit_digit == ipk_pkg::DIGIT_LAST) ? ipk_pkg::ZERO3
               : state_reg.edit_digit + ipk_pkg::ONE3; // R13
         end else if (state_reg.menu == ipk_pkg::IPK_MENU_SCREEN) begin
            state_next.mon_sel = (state_reg.mon_sel == ipk_pkg::MON_LAST) ? ipk_pkg::ZERO3
               : state_reg.mon_sel + ipk_pkg::ONE3; // R12
         end
      end

      // Drive command keys act on every screen.
      if (press[ipk_pkg::KEY_RUN] && i_drive.keypad_mode) begin
         state_next.act.run_cmd = 1'b1; // R14
      end
      if (press[ipk_pkg::KEY_STOP]) begin
         if (i_drive.fault_active) begin
            state_next.act.fault_reset = i_stop_key_behaviour_setting[ipk_pkg::STOP_SET_RESET]; // R16
         end else if (i_drive.running
                      && (i_drive.keypad_mode || i_stop_key_behaviour_setting[ipk_pkg::STOP_SET_STOP_ANY])) begin
            state_next.act.stop_cmd = 1'b1; // R15
         end
      end
      if (press[ipk_pkg::KEY_MULTI]) begin
         case (i_multifunction_key_assignment)
            ipk_pkg::IPK_MK_CMD_SWITCH: begin
               state_next.act.mk_cmd_switch = 1'b1; // R17
            end
            ipk_pkg::IPK_MK_DIR_SWITCH: begin
               state_next.act.mk_dir_switch = 1'b1; // R17
            end
            ipk_pkg::IPK_MK_JOG_FWD: begin
               state_next.act.mk_jog_fwd = 1'b1; // R17
            end
            ipk_pkg::IPK_MK_JOG_REV: begin
               state_next.act.mk_jog_rev = 1'b1; // R17
            end
            ipk_pkg::IPK_MK_VIEW_MODE: begin
               state_next.act.mk_view_mode = 1'b1; // R17
            end
            default: begin
               state_next.act.mk_cmd_switch = 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         state_reg <= '0;
         state_reg.sync1 <= '1;
         state_reg.sync2 <= '1;
      end else if (i_clk_en) begin
         state_reg <= state_next;
      end
   end

   assign o_lamps = state_reg.lamps;
   assign o_digit_segs = state_reg.segs;
   assign o_digit_flash = state_reg.flash;
   assign o_menu_level = state_reg.menu;
   assign o_monitor_sel = state_reg.mon_sel;
   assign o_edit_digit = state_reg.edit_digit;
   assign o_actions = state_reg.act;

endmodule : ipk_panel

/* File: bench/ipk_panel_monitor.sv */
// Concurrent checks on the operating panel top ports.
`timescale 1ns/1ps
module ipk_panel_monitor (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_clk_en,
   input wire ipk_pkg::ipk_drive_state_t i_drive,
   input wire logic [1:0] i_stop_key_behaviour_setting,
   input wire logic [39:0] i_digit_segs,
   input wire ipk_pkg::ipk_lamps_t o_lamps,
   input wire logic [39:0] o_digit_segs,
   input wire ipk_pkg::ipk_menu_t o_menu_level,
   input wire ipk_pkg::ipk_actions_t o_actions
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   property p_lamp_stop;
      i_clk_en && !i_drive.running && !i_drive.changing_over |=> o_lamps.lamp_fwd == $past(i_drive.fwd_cmd_valid)
         && o_lamps.lamp_rev == $past(i_drive.rev_cmd_valid);
   endproperty
   a_lamp_stop: assert property (p_lamp_stop)
      else $error("stopped lamps wrong");
   property p_lamp_run;
      i_clk_en && i_drive.running && !i_drive.changing_over |=> o_lamps.lamp_fwd != $past(i_drive.dir_rev)
         && o_lamps.lamp_rev == $past(i_drive.dir_rev);
   endproperty
   a_lamp_run: assert property (p_lamp_run)
      else $error("running lamps wrong");
   property p_lamp_co;
      i_clk_en && i_drive.changing_over |=> $past(i_drive.dir_rev) ? !o_lamps.lamp_fwd : !o_lamps.lamp_rev;
   endproperty
   a_lamp_co: assert property (p_lamp_co)
      else $error("wrong lamp lit in change over");
   property p_unit_pct;
      i_clk_en && i_drive.percent_unit |=> o_lamps.lamp_a && o_lamps.lamp_v && !o_lamps.lamp_hz;
   endproperty
   a_unit_pct: assert property (p_unit_pct)
      else $error("percent unit lamps wrong");
   property p_unit_speed;
      i_clk_en && !i_drive.percent_unit && i_drive.unit == ipk_pkg::IPK_UNIT_SPEED
         |=> o_lamps.lamp_hz && o_lamps.lamp_a && !o_lamps.lamp_v;
   endproperty
   a_unit_speed: assert property (p_unit_speed)
      else $error("speed unit lamps wrong");
   property p_segs;
      i_clk_en |=> o_digit_segs == $past(i_digit_segs);
   endproperty
   a_segs: assert property (p_segs)
      else $error("digit segments wrong");
   property p_menu_enter;
      o_menu_level == ipk_pkg::IPK_MENU_SCREEN ##1 o_menu_level != ipk_pkg::IPK_MENU_SCREEN
         |-> o_menu_level == ipk_pkg::IPK_MENU_GROUP;
   endproperty
   a_menu_enter: assert property (p_menu_enter)
      else $error("menu left screen to wrong level");
   property p_run;
      o_actions.run_cmd |-> $past(i_drive.keypad_mode);
   endproperty
   a_run: assert property (p_run)
      else $error("run outside keypad mode");
   property p_stop;
      o_actions.stop_cmd |-> $past(i_drive.running);
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop while not running");
   property p_fault;
      o_actions.fault_reset |-> $past(i_stop_key_behaviour_setting[1]) && $past(i_drive.fault_active);
   endproperty
   a_fault: assert property (p_fault)
      else $error("fault reset not allowed");
   property p_pulse;
      i_clk_en && o_actions != '0 |=> (o_actions & $past(o_actions)) == '0;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("action longer than one cycle");
   c_run: cover property (o_actions.run_cmd);
   c_fault: cover property (o_actions.fault_reset);
   c_flash: cover property (i_drive.changing_over && $rose(o_lamps.lamp_fwd));
endmodule : ipk_panel_monitor

bind ipk_panel ipk_panel_monitor u_mon (.i_sys_clk, .i_reset, .i_clk_en, .i_drive, .i_stop_key_behaviour_setting,
   .i_digit_segs, .o_lamps, .o_digit_segs, .o_menu_level, .o_actions);

/* File: bench/ipk_operator.sv */
// Operator model: presses one key, with optional contact bounce on press and release.
`timescale 1ns/1ps
module ipk_operator (
   input wire logic i_sys_clk,
   input wire logic i_go,
   input wire logic [2:0] i_key,
   input wire logic i_bounce,
   output logic [7:0] o_key_pins_n,
   output logic o_busy
);
   int cnt = 0;
   logic [2:0] k = '0;
   logic b = 1'b0;
   logic pressed;
   initial o_busy = 1'b0;
   // Pins are pulled up, so a released key reads high.
   assign pressed = o_busy && ((cnt < 16 && !(b && cnt == 1)) || (b && cnt == 17));
   assign o_key_pins_n = ~(8'(pressed) << k);
   always @(posedge i_sys_clk) begin
      if (!o_busy && i_go) begin
         o_busy <= 1'b1;
         k <= i_key;
         b <= i_bounce;
         cnt <= 0;
      end else if (o_busy) begin
         cnt <= cnt + 1;
         if (cnt == 40) o_busy <= 1'b0;
      end
   end
endmodule : ipk_operator

/* File: bench/tb_ipk_panel.sv */
// Self-checking testbench for the operating panel.
`timescale 1ns/1ps
module tb_ipk_panel;
   logic clk = 0, reset = 1, clk_en, go, bounce, busy, cnt_on, prev;
   logic [7:0] pins_n;
   logic [2:0] key, mon, edit, m_mon, m_edit;
   logic [1:0] stset;
   logic [39:0] segs, segs_o;
   logic [4:0] flash;
   logic [31:0] seed = 32'h780C7CD0;
   ipk_pkg::ipk_drive_state_t drv, d;
   ipk_pkg::ipk_mk_func_t mk;
   ipk_pkg::ipk_lamps_t lamps;
   ipk_pkg::ipk_menu_t menu, m_menu;
   ipk_pkg::ipk_actions_t act, acc;
   int err_total = 0, check_count = 0, pulses, i, j, t;
   int dir[] = '{1, 1, 1, 4, 4, 4, 4, 4, 4, 3, 2, 1, 1, 0, 4, 4, 4, 4, 4, 4, 4, 4, 4, 0, 1, 0};
   ipk_panel #(.DEBOUNCE_CYCLES(4), .BLINK_HALF_CYCLES(8)) DUT (.i_sys_clk(clk), .i_reset(reset),
      .i_clk_en(clk_en), .i_key_pins_n(pins_n), .i_drive(drv), .i_stop_key_behaviour_setting(stset),
      .i_multifunction_key_assignment(mk), .i_digit_segs(segs), .o_lamps(lamps), .o_digit_segs(segs_o),
      .o_digit_flash(flash), .o_menu_level(menu), .o_monitor_sel(mon), .o_edit_digit(edit), .o_actions(act));
   ipk_operator u_op (.i_sys_clk(clk), .i_go(go), .i_key(key), .i_bounce(bounce), .o_key_pins_n(pins_n),
      .o_busy(busy));
   initial forever #2 clk = ~clk;
   // Action pulses are collected only while a press is in progress.
   always @(posedge clk) if (!cnt_on) begin
      acc <= '0;
      pulses <= 0;
   end else if (act != '0) begin
      acc <= acc | act;
      pulses <= pulses + 1;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic ipk_pkg::ipk_lamps_t exp_lamps(ipk_pkg::ipk_drive_state_t s);
      ipk_pkg::ipk_lamps_t l;
      l = '0;
      l.lamp_fwd = s.running ? !s.dir_rev : s.fwd_cmd_valid;
      l.lamp_rev = s.running ? s.dir_rev : s.rev_cmd_valid;
      l.lamp_hz = !s.percent_unit && s.unit inside {ipk_pkg::IPK_UNIT_HZ, ipk_pkg::IPK_UNIT_SPEED};
      l.lamp_a = s.percent_unit || s.unit inside {ipk_pkg::IPK_UNIT_A, ipk_pkg::IPK_UNIT_SPEED};
      l.lamp_v = s.percent_unit || s.unit == ipk_pkg::IPK_UNIT_V;
      return l;
   endfunction : exp_lamps
   function automatic ipk_pkg::ipk_actions_t exp_act(int k);
      ipk_pkg::ipk_actions_t a;
      logic v;
      a = '0;
      v = m_menu == ipk_pkg::IPK_MENU_VALUE;
      case (k)
         0: a.cancel_edit = v;
         1: a.accept_edit = v;
         2: begin a.value_inc = v; a.code_inc = !v; end
         3: begin a.value_dec = v; a.code_dec = !v; end
         5: a.run_cmd = drv.keypad_mode;
         6: if (drv.fault_active) a.fault_reset = stset[1];
            else a.stop_cmd = drv.running && (drv.keypad_mode || stset[0]);
         7: if (mk != ipk_pkg::IPK_MK_NONE) a = 14'(1) << (5 - mk);
         default: ;
      endcase
      return a;
   endfunction : exp_act
   task automatic check(string n, logic [63:0] s, logic [63:0] e);
      check_count++;
      if (s !== e) begin
         err_total++;
         $display("Error %s expected %0h seen %0h", n, e, s);
      end
   endtask : check
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop
   task automatic press(int k, logic b);
      ipk_pkg::ipk_actions_t e;
      int n;
      n = 0;
      @(posedge clk);
      cnt_on <= 1;
      go <= 1;
      key <= 3'(k);
      bounce <= b;
      e = exp_act(k);
      @(posedge clk);
      go <= 0;
      #1;
      while (busy && n < 100) begin @(posedge clk); #1; n++; end
      cnt_on <= 0;
      check("press done", n < 100, 1);
      check("actions", acc, e);
      check("pulse count", pulses, e != '0);
      if (k == 0) m_menu = m_menu == ipk_pkg::IPK_MENU_SCREEN ? ipk_pkg::IPK_MENU_GROUP : ipk_pkg::IPK_MENU_SCREEN;
      if (k == 1) begin
         if (m_menu == ipk_pkg::IPK_MENU_CODE) m_edit = 0;
         m_menu = m_menu == ipk_pkg::IPK_MENU_VALUE ? ipk_pkg::IPK_MENU_CODE : ipk_pkg::ipk_menu_t'(m_menu + 1);
      end
      if (k == 4 && m_menu == ipk_pkg::IPK_MENU_VALUE) m_edit = m_edit == 4 ? 0 : m_edit + 1;
      if (k == 4 && m_menu == ipk_pkg::IPK_MENU_SCREEN) m_mon = m_mon + 1;
      check("menu", menu, m_menu);
      check("monitor", mon, m_mon);
      check("edit digit", edit, m_edit);
      check("flash", flash, m_menu == ipk_pkg::IPK_MENU_VALUE ? 5'(1) << m_edit : 5'(0));
   endtask : press
   initial begin
      clk_en = 1; go = 0; key = 0; bounce = 0; cnt_on = 0; stset = 0; segs = '0; drv = '0;
      mk = ipk_pkg::IPK_MK_NONE; m_menu = ipk_pkg::IPK_MENU_SCREEN; m_mon = 0; m_edit = 0;
      repeat (2) @(posedge clk);
      reset <= 0;
      foreach (dir[n]) press(dir[n], n % 2);
      $display("test menu walk done");
      for (i = 0; i < 6; i++) begin
         @(posedge clk);
         mk <= ipk_pkg::ipk_mk_func_t'(i);
         press(7, 1);
      end
      $display("test multifunction done");
      for (i = 0; i < 60; i++) begin
         d = ipk_pkg::ipk_drive_state_t'(xs());
         d.changing_over = 0;
         @(posedge clk);
         stset <= 2'(xs());
         drv <= d;
         mk <= ipk_pkg::ipk_mk_func_t'(3'(xs() % 6));
         segs <= {8'(xs()), xs()};
         repeat (2) @(posedge clk);
         #1;
         check("lamps", lamps, exp_lamps(drv));
         check("segments", segs_o, segs);
         press(xs() % 8, xs() % 2);
      end
      $display("test random keys done");
      for (j = 0; j < 2; j++) begin
         d = '0;
         d.changing_over = 1'b1;
         d.dir_rev = j[0];
         @(posedge clk);
         drv <= d;
         @(posedge clk);
         #1;
         t = 0;
         prev = j ? lamps.lamp_rev : lamps.lamp_fwd;
         for (i = 0; i < 48; i++) begin
            @(posedge clk);
            #1;
            if ((j ? lamps.lamp_rev : lamps.lamp_fwd) != prev) t++;
            prev = j ? lamps.lamp_rev : lamps.lamp_fwd;
         end
         check("blink toggles", t >= 5 && t <= 7, 1);
      end
      $display("test change over done");
      report_and_stop;
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      $display("Error watchdog expected finish seen timeout");
      report_and_stop;
   end
endmodule : tb_ipk_panel
